//--- rtl/hpc2_pkg.sv
// package: register map, field positions and reset values of the second host port control register
// What this block does
// - control register two is writable and reads back the last written control bits
// - bit 0 set in daisy-chain mode raises interrupt on configuration data request
// - data request enable works only in daisy-chain mode; all fields reset to zero
// - bit 1 set raises interrupt on bit stream error during configuration only
// - writing zero to a configuration interrupt enable clears it and its interrupt
// - bit 2 set forwards low user interrupt request; cleared enable blocks it
// - bit 3 set enables daisy-chain output of configuration data
// - bit 4 set holds configuration byte write acknowledge until byte serialized
// - bytes serialize only with daisy output enabled, so holding applies only then
// - bit 4 clear acknowledges each configuration data byte transfer at once
// - user mode may alternatively be enabled by a bit stream setting
// - status register is read-only; host writes leave it unchanged
// - control register two decodes at host address 01 hexadecimal
// - interrupt pending status bit sets on pending request, clears on a status read while no request is active
package hpc2_pkg;
    localparam int          HPC2_AW          = 5;
    localparam logic [4:0]  HPC2_ADDR_CTRL2  = 5'h01;
    localparam logic [4:0]  HPC2_ADDR_STATUS = 5'h03;
    localparam logic [4:0]  HPC2_ADDR_CFGDAT = 5'h04;
    localparam logic [7:0]  HPC2_CTRL2_RESET = 8'h00;
    localparam logic [7:0]  HPC2_CTRL2_MASK  = 8'h3F;
    localparam int          HPC2_BIT_CFGIRQ  = 0;
    localparam int          HPC2_BIT_ERRIRQ  = 1;
    localparam int          HPC2_BIT_USRIRQ  = 2;
    localparam int          HPC2_BIT_DAISY   = 3;
    localparam int          HPC2_BIT_HOLD    = 4;
    localparam int          HPC2_BIT_USER    = 5;
    localparam int          HPC2_ST_DREADY   = 1;
    localparam int          HPC2_ST_PEND     = 2;
    localparam int          HPC2_ST_ERRLO    = 3;
    localparam int          HPC2_ST_INIT     = 6;
    localparam int          HPC2_ST_DONE     = 7;
    localparam logic [2:0]  HPC2_SYNC_RESET  = 3'h7;

    typedef struct packed {
        logic                 req;
        logic                 write;
        logic [HPC2_AW-1:0]   addr;
        logic [7:0]           wdata;
    } hpc2_req_t;

    typedef struct packed {
        logic       dataReady;
        logic [1:0] errorCode;
        logic       initPin;
        logic       donePin;
    } hpc2_cfgstat_t;

    typedef enum logic [0:0] {HPC2_IDLE, HPC2_HOLD} hpc2_state_t;
endpackage

//--- rtl/hpc2_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module hpc2_sync
    import hpc2_pkg::*;
(
    input  wire logic clock,   // port clock
    input  wire logic resetn,  // async reset, active low
    input  wire logic din,     // asynchronous input
    output var  logic dout     // filtered level
);
    logic [2:0] stage_q;
    logic       level_q;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stage_q <= HPC2_SYNC_RESET;
        end else begin
            stage_q <= {stage_q[1:0], din};
        end
    end

    // only stages two and three are looked at; stage one may be metastable
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            level_q <= HPC2_SYNC_RESET[0];
        end else if (stage_q[1] == stage_q[2]) begin
            level_q <= stage_q[2];
        end
    end

    assign dout = level_q;
endmodule // hpc2_sync
`default_nettype wire

//--- rtl/hpc2_top.sv
// second host port control register with interrupt gating and byte write acknowledge
`timescale 1ns/100ps
`default_nettype none
module hpc2_top
    import hpc2_pkg::*;
(
    input  wire logic          clock,                 // host interface clock
    input  wire logic          resetn,                // async reset, active low
    input  wire hpc2_req_t     hostReq,               // host access request
    output logic [7:0]         hostRdata_q,           // read data
    output logic               hostAck_q,             // access acknowledge pulse
    input  wire logic          daisyConfigMode,       // daisy-chain configuration active
    input  wire logic          configInProgress,      // configuration running
    input  wire logic          cfgDataRequest,        // data register needs or holds a byte
    input  wire logic          bitstreamError,        // bit stream error seen
    input  wire logic          byteSerialized,        // configuration logic serialized a byte
    input  wire logic          bitstreamUserMode,     // user mode set by bit stream
    input  wire hpc2_cfgstat_t cfgStatus,             // status inputs of the configuration logic
    input  wire logic [7:0]    cfgReadData,           // readback byte
    input  wire logic          user_interrupt_request_n, // user interrupt, active low, async
    output logic               host_interrupt_pin_q,  // interrupt to host, active high
    output logic               cfgWriteStrobe_q,      // configuration byte write pulse
    output logic [7:0]         cfgWriteData_q,        // configuration byte
    output logic               daisy_output_enable_q, // daisy-chain output enable
    output logic               hold_ack_until_serialized_q, // hold field
    output logic               userModeActive_q       // port in user mode
);
    logic [7:0]   ctrl2_q;
    logic         irqPending_q;
    hpc2_state_t  state_q;
    logic         userReqN;
    logic         irqSource;
    logic         cfgSource;
    logic         errSource;
    logic         usrSource;
    logic         accCtrl2Wr;
    logic         accStatusRd;
    logic         accCfgWr;
    logic         holdNeeded;
    logic         accept;
    logic [7:0]   statusByte;
    logic [7:0]   readByte;

    hpc2_sync u_usr_sync (
        .clock  (clock),
        .resetn (resetn),
        .din    (user_interrupt_request_n),
        .dout   (userReqN)
    );

    // requests arriving while a held write waits are ignored
    assign accept      = hostReq.req && (state_q == HPC2_IDLE);
    assign accCtrl2Wr  = accept && hostReq.write && (hostReq.addr == HPC2_ADDR_CTRL2);
    assign accStatusRd = accept && !hostReq.write && (hostReq.addr == HPC2_ADDR_STATUS);
    assign accCfgWr    = accept && hostReq.write && (hostReq.addr == HPC2_ADDR_CFGDAT);
    assign holdNeeded  = ctrl2_q[HPC2_BIT_HOLD] && ctrl2_q[HPC2_BIT_DAISY];

    assign cfgSource = ctrl2_q[HPC2_BIT_CFGIRQ] && daisyConfigMode && cfgDataRequest;
    // error source only counts while configuration runs
    assign errSource = ctrl2_q[HPC2_BIT_ERRIRQ] && configInProgress && bitstreamError;
    // synchronised level only, never the raw pin
    assign usrSource = ctrl2_q[HPC2_BIT_USRIRQ] && !userReqN;
    assign irqSource = cfgSource || errSource || usrSource;

    always_comb begin
        statusByte = 8'h00;
        statusByte[HPC2_ST_DREADY] = cfgStatus.dataReady;
        statusByte[HPC2_ST_PEND] = irqPending_q;
        statusByte[HPC2_ST_ERRLO +: 2] = cfgStatus.errorCode;
        statusByte[HPC2_ST_INIT] = cfgStatus.initPin;
        statusByte[HPC2_ST_DONE] = cfgStatus.donePin;
    end

    always_comb begin
        unique case (hostReq.addr)
            HPC2_ADDR_CTRL2:  readByte = ctrl2_q & HPC2_CTRL2_MASK;
            HPC2_ADDR_STATUS: readByte = statusByte;
            HPC2_ADDR_CFGDAT: readByte = cfgReadData;
            default:          readByte = 8'h00;
        endcase
    end

    // control register; writing zero to an enable drops its source at once
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl2_q <= HPC2_CTRL2_RESET;
        end else if (accCtrl2Wr) begin
            ctrl2_q <= hostReq.wdata & HPC2_CTRL2_MASK;
        end
    end

    // status register has no write path at all
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irqPending_q <= 1'b0;
        end else if (irqSource) begin
            irqPending_q <= 1'b1;
        end else if (accStatusRd) begin
            irqPending_q <= 1'b0;
        end
    end

    // a request still held by user logic keeps the pin asserted
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            host_interrupt_pin_q <= 1'b0;
        end else begin
            host_interrupt_pin_q <= irqSource;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q <= HPC2_IDLE;
        end else begin
            unique case (state_q)
                HPC2_IDLE: begin
                    if (accCfgWr && holdNeeded) begin
                        state_q <= HPC2_HOLD;
                    end
                end
                HPC2_HOLD: begin
                    if (byteSerialized) begin
                        state_q <= HPC2_IDLE;
                    end
                end
            endcase
        end
    end

    // a held byte write is answered only once the byte has left
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hostAck_q <= 1'b0;
        end else begin
            hostAck_q <= (accept && !(accCfgWr && holdNeeded))
                      || ((state_q == HPC2_HOLD) && byteSerialized);
        end
    end

    // read data stands until the next read, so a slow host may pick it up late
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hostRdata_q <= 8'h00;
        end else if (accept && !hostReq.write) begin
            hostRdata_q <= readByte;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cfgWriteStrobe_q <= 1'b0;
        end else begin
            cfgWriteStrobe_q <= accCfgWr;
        end
    end

    // byte is kept after the strobe so the serializer may take it late
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cfgWriteData_q <= 8'h00;
        end else if (accCfgWr) begin
            cfgWriteData_q <= hostReq.wdata;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            daisy_output_enable_q <= 1'b0;
        end else begin
            daisy_output_enable_q <= ctrl2_q[HPC2_BIT_DAISY];
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hold_ack_until_serialized_q <= 1'b0;
        end else begin
            hold_ack_until_serialized_q <= ctrl2_q[HPC2_BIT_HOLD];
        end
    end

    // a level, not latched at done: clearing both sources leaves user mode
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            userModeActive_q <= 1'b0;
        end else begin
            userModeActive_q <= ctrl2_q[HPC2_BIT_USER] || bitstreamUserMode;
        end
    end
endmodule // hpc2_top
`default_nettype wire

//--- verification/hpc2_checker.sv
// concurrent checks on the second host port control register
`timescale 1ns/100ps
`default_nettype none
module hpc2_checker
    import hpc2_pkg::*;
(
    input wire logic       clock,                       // clock
    input wire logic       resetn,                      // reset
    input wire hpc2_req_t  hostReq,                     // request
    input wire logic [7:0] hostRdata_q,                 // read data
    input wire logic       hostAck_q,                   // ack
    input wire logic       daisyConfigMode,             // daisy mode
    input wire logic       configInProgress,            // configuring
    input wire logic       cfgDataRequest,              // data request
    input wire logic       bitstreamError,              // stream error
    input wire logic       bitstreamUserMode,           // stream user mode
    input wire logic       user_interrupt_request_n,    // user irq
    input wire logic       host_interrupt_pin_q,        // host irq
    input wire logic       cfgWriteStrobe_q,            // byte strobe
    input wire logic       daisy_output_enable_q,       // daisy enable
    input wire logic       hold_ack_until_serialized_q, // hold field
    input wire logic       userModeActive_q             // user mode
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    logic [2:0] usrHigh_q;
    wire logic wr2 = hostReq.req && hostReq.write && hostReq.addr == HPC2_ADDR_CTRL2;
    wire logic rd2 = hostReq.req && !hostReq.write && hostReq.addr == HPC2_ADDR_CTRL2;
    wire logic cfgWr = hostReq.req && hostReq.write && hostReq.addr == HPC2_ADDR_CFGDAT;
    wire logic held = hold_ack_until_serialized_q && daisy_output_enable_q;
    // user source counts as quiet only once the synchroniser has flushed
    always_ff @(posedge clock or negedge resetn)
        if (!resetn) usrHigh_q <= 3'h0;
        else if (!user_interrupt_request_n) usrHigh_q <= 3'h0;
        else if (usrHigh_q != 3'h7) usrHigh_q <= usrHigh_q + 3'h1;
    daisy_follow_a: assert property (wr2 ##1 hostAck_q |=>
        daisy_output_enable_q == $past(hostReq.wdata[HPC2_BIT_DAISY], 2)) else $error("daisy enable wrong");
    hold_follow_a: assert property (wr2 ##1 hostAck_q |=>
        hold_ack_until_serialized_q == $past(hostReq.wdata[HPC2_BIT_HOLD], 2)) else $error("hold field wrong");
    stream_user_a: assert property (bitstreamUserMode ##1 bitstreamUserMode |-> userModeActive_q)
        else $error("stream user mode ignored");
    reserved_zero_a: assert property (rd2 ##1 hostAck_q |-> hostRdata_q[7:6] == 2'h0)
        else $error("reserved bits read nonzero");
    irq_cause_a: assert property (host_interrupt_pin_q && usrHigh_q == 3'h7 |->
        $past(cfgDataRequest && daisyConfigMode || bitstreamError && configInProgress)) else $error("irq no cause");
    reset_clear_a: assert property ($rose(resetn) |-> !host_interrupt_pin_q && !hostAck_q
        && !daisy_output_enable_q && !hold_ack_until_serialized_q) else $error("outputs not cleared");
    quick_ack_a: assert property (cfgWr && !held |=> hostAck_q && cfgWriteStrobe_q)
        else $error("byte write not acked at once");
    held_ack_a: assert property (cfgWr && held |=> cfgWriteStrobe_q && !hostAck_q)
        else $error("held byte acked early");
    cover property (cfgWr && held);
    cover property (host_interrupt_pin_q);
    cover property (rd2 ##1 hostAck_q);
endmodule // hpc2_checker
bind hpc2_top hpc2_checker u_chk (.clock(clock), .resetn(resetn), .hostReq(hostReq), .hostRdata_q(hostRdata_q),
    .hostAck_q(hostAck_q), .daisyConfigMode(daisyConfigMode), .configInProgress(configInProgress),
    .cfgDataRequest(cfgDataRequest), .bitstreamError(bitstreamError), .bitstreamUserMode(bitstreamUserMode),
    .user_interrupt_request_n(user_interrupt_request_n), .host_interrupt_pin_q(host_interrupt_pin_q),
    .cfgWriteStrobe_q(cfgWriteStrobe_q), .daisy_output_enable_q(daisy_output_enable_q),
    .hold_ack_until_serialized_q(hold_ack_until_serialized_q), .userModeActive_q(userModeActive_q));
`default_nettype wire

//--- verification/hpc2_host.sv
// host processor model issuing single-byte register accesses
`timescale 1ns/100ps
`default_nettype none
module hpc2_host
    import hpc2_pkg::*;
(
    input  wire logic       clock,       // port clock
    input  wire logic       hostAck_q,   // ack
    input  wire logic [7:0] hostRdata_q, // read data
    output var  hpc2_req_t  hostReq      // request
);
    logic [7:0] rdata;
    int         cyc;
    initial hostReq = '0;
    // one-cycle pulse, then bounded wait: a held write may take long
    task automatic acc(input logic wr, input logic [4:0] addr, input logic [7:0] wd);
        hostReq <= '{1'b1, wr, addr, wd};
        @(posedge clock);
        hostReq <= '0;
        cyc = 0;
        do begin
            @(posedge clock);
            cyc++;
        end while (!hostAck_q && cyc < 40);
        rdata = hostRdata_q;
    endtask
endmodule // hpc2_host
`default_nettype wire

//--- verification/hpc2_bench.sv
// self-checking bench of the second host port control register
`timescale 1ns/100ps
`default_nettype none
module host_port_control_two_bench;
    import hpc2_pkg::*;
    logic clock = 0, resetn = 0, daisyMode = 0, cfgBusy = 0, dataReq = 0, streamErr = 0;
    logic serDone = 0, streamUser = 0, userIrqN = 1, ack, irq, stb, dsy, hld, usr;
    logic [7:0] rdat, wdat;
    hpc2_req_t req;
    hpc2_cfgstat_t cst = '{1'b1, 2'h2, 1'b1, 1'b0};
    int n_fail = 0, checks = 0;
    logic [15:0] rows [4] = '{16'hF737, 16'h1515, 16'hEA2A, 16'h0000};
    always #2.5 clock = ~clock;
    hpc2_host u_host (.clock(clock), .hostAck_q(ack), .hostRdata_q(rdat), .hostReq(req));
    hpc2_top u_dut (.clock(clock), .resetn(resetn), .hostReq(req), .hostRdata_q(rdat), .hostAck_q(ack),
        .daisyConfigMode(daisyMode), .configInProgress(cfgBusy), .cfgDataRequest(dataReq),
        .bitstreamError(streamErr), .byteSerialized(serDone), .bitstreamUserMode(streamUser), .cfgStatus(cst),
        .cfgReadData(8'h5A), .user_interrupt_request_n(userIrqN), .host_interrupt_pin_q(irq),
        .cfgWriteStrobe_q(stb), .cfgWriteData_q(wdat), .daisy_output_enable_q(dsy),
        .hold_ack_until_serialized_q(hld), .userModeActive_q(usr));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        u_host.acc(1'b0, a, 8'h00);
        chk(u_host.rdata, exp);
    endtask
    // write control, let the synchroniser settle, then look at the pin
    task automatic irqCase(input logic [7:0] ctl, input logic exp);
        u_host.acc(1'b1, HPC2_ADDR_CTRL2, ctl);
        repeat (8) @(posedge clock);
        chk({7'h0, irq}, {7'h0, exp});
    endtask
    initial begin
        #200000;
        n_fail++;
        close_out;
    end
    initial begin
        repeat (16) @(posedge clock);
        resetn <= 1;
        @(posedge clock);
        foreach (rows[i]) begin
            u_host.acc(1'b1, HPC2_ADDR_CTRL2, rows[i][15:8]);
            rd(HPC2_ADDR_CTRL2, rows[i][7:0]);
            chk({6'h0, hld, dsy}, {6'h0, rows[i][4:3]});
        end
        u_host.acc(1'b1, HPC2_ADDR_CTRL2, 8'h3F);
        resetn <= 0;
        @(posedge clock);
        resetn <= 1;
        @(posedge clock);
        rd(HPC2_ADDR_CTRL2, 8'h00);
        rd(5'h0B, 8'h00);
        u_host.acc(1'b1, HPC2_ADDR_STATUS, 8'hFF);
        rd(HPC2_ADDR_STATUS, 8'h52);
        dataReq <= 1;
        daisyMode <= 1;
        irqCase(8'h01, 1'b1);
        irqCase(8'h00, 1'b0);
        daisyMode <= 0;
        irqCase(8'h01, 1'b0);
        dataReq <= 0;
        streamErr <= 1;
        irqCase(8'h02, 1'b0);
        cfgBusy <= 1;
        irqCase(8'h02, 1'b1);
        streamErr <= 0;
        rd(HPC2_ADDR_STATUS, 8'h56);
        rd(HPC2_ADDR_STATUS, 8'h52);
        userIrqN <= 0;
        irqCase(8'h04, 1'b1);
        irqCase(8'h00, 1'b0);
        irqCase(8'h04, 1'b1);
        userIrqN <= 1;
        irqCase(8'h04, 1'b0);
        streamUser <= 1;
        irqCase(8'h00, 1'b0);
        chk({7'h0, usr}, 8'h01);
        streamUser <= 0;
        irqCase(8'h20, 1'b0);
        cst.donePin <= 1;
        chk({7'h0, usr}, 8'h01);
        u_host.acc(1'b1, HPC2_ADDR_CTRL2, 8'h18);
        fork
            u_host.acc(1'b1, HPC2_ADDR_CFGDAT, 8'hA5);
            begin
                repeat (2) @(posedge clock);
                chk({7'h0, stb}, 8'h01);
                repeat (3) @(posedge clock);
                serDone <= 1;
                @(posedge clock);
                serDone <= 0;
            end
        join
        chk(u_host.cyc[7:0], 8'h06);
        chk(wdat, 8'hA5);
        foreach (rows[i]) begin
            u_host.acc(1'b1, HPC2_ADDR_CTRL2, rows[i][7:0] & 8'h1F);
            u_host.acc(1'b1, HPC2_ADDR_CFGDAT, 8'h3C);
            chk(u_host.cyc[7:0], 8'h01);
        end
        rd(HPC2_ADDR_CFGDAT, 8'h5A);
        close_out;
    end
endmodule // host_port_control_two_bench
`default_nettype wire
